// >>> bgc_pkg.sv
// Constants and types shared by the bridge gate control logic.
package bgc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned QUAL_STEP_NS = 100;
  localparam int unsigned QUAL_DEF_NS = 1600;
  localparam int unsigned QUAL_MIN_NS = 600;
  localparam int unsigned QUAL_MAX_NS = 6300;
  localparam int unsigned QUAL_STEP_CYC = (CLK_HZ / 1_000_000) * QUAL_STEP_NS / 1000;
  localparam int unsigned QUAL_DEF_CODE = QUAL_DEF_NS / QUAL_STEP_NS;
  localparam int unsigned QUAL_MIN_CODE = QUAL_MIN_NS / QUAL_STEP_NS;
  localparam int unsigned QUAL_MAX_CODE = QUAL_MAX_NS / QUAL_STEP_NS;
  localparam int unsigned QUAL_W = 6;
  localparam int unsigned CLK_DIV_RATIO = 280000;
  localparam int unsigned FAULT_INDICATOR_PIN_PERIOD_MS = 100;
  localparam int unsigned FAULT_INDICATOR_PIN_PERIOD_CYC = FAULT_INDICATOR_PIN_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned DUTY_OK_PCT = 80;
  localparam int unsigned DUTY_FAULT_PCT = 20;
  localparam int unsigned EN_TIMEOUT_MS = 100;
  localparam int unsigned EN_TIMEOUT_CYC = EN_TIMEOUT_MS * (CLK_HZ / 1000);

  ////////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam int unsigned CTRL_HI_LSB = 0;
  localparam int unsigned CTRL_LO_LSB = 4;
  localparam int unsigned CFG_DMODE_LSB = 0;
  localparam int unsigned CFG_CKS_BIT = 2;
  localparam int unsigned CFG_VDQ_BIT = 3;
  localparam int unsigned CFG_OCQ_BIT = 4;
  localparam int unsigned CFG_WDM_BIT = 5;
  localparam int unsigned CFG_QUAL_LSB = 8;
  localparam int unsigned STAT_VDS_BIT = 0;
  localparam int unsigned STAT_OC_BIT = 1;
  localparam int unsigned STAT_EN_BIT = 8;
  localparam int unsigned STAT_WDTO_BIT = 9;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] DMODE_RST = 2'h0;
  localparam logic [5:0] QUAL_RST = 6'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Indicator pin modes, in field order.
  typedef enum logic [1:0] {
    FAULT_INDICATOR_PIN_LEVEL,
    FAULT_INDICATOR_PIN_PULSE,
    FAULT_INDICATOR_PIN_LIVE,
    FAULT_INDICATOR_PIN_CLOCK
  } bgc_fault_indicator_pin_mode_t;

endpackage

// >>> bgc_qual_if.sv
// Interface between the control core and a fault qualifier.
`timescale 1ns/1ps
interface bgc_qual_if;
  logic raw;
  logic gate_on;
  logic blank_mode;
  logic [5:0] qual_cyc;
  logic fault;
  modport ctrl (output raw, output gate_on, output blank_mode, output qual_cyc, input fault);
  modport qual (input raw, input gate_on, input blank_mode, input qual_cyc, output fault);
endinterface

// >>> bgc_qualifier.sv
// Fault qualifier working as debounce filter or blanking window.
`timescale 1ns/1ps
module bgc_qualifier (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  bgc_qual_if.qual q
);

  typedef struct packed {
    logic [5:0] cnt;
    logic fault;
  } bgc_qual_st_t;

  bgc_qual_st_t st_r;
  bgc_qual_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Debounce needs the raw level for the whole time; blanking ignores it after turn-on.
  always_comb
  begin
    st_nxt = st_r;
    if (q.blank_mode)
    begin
      if (q.gate_on)
      begin
        st_nxt.cnt = 6'h00;
        st_nxt.fault = 1'b0;
      end
      else if (st_r.cnt < q.qual_cyc)
      begin
        st_nxt.cnt = st_r.cnt + 6'h01;
        st_nxt.fault = 1'b0;
      end
      else
      begin
        st_nxt.fault = q.raw;
      end
    end
    else
    begin
      if (!q.raw)
      begin
        st_nxt.cnt = 6'h00;
      end
      else if (st_r.cnt < q.qual_cyc)
      begin
        st_nxt.cnt = st_r.cnt + 6'h01;
      end
      st_nxt.fault = q.raw && (st_nxt.cnt == q.qual_cyc);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q.fault = st_r.fault;

endmodule

// >>> bgc_divider.sv
// Free-running modulo counter with a wrap pulse.
`timescale 1ns/1ps
module bgc_divider #(
  parameter int unsigned DIV = 280000,
  parameter int unsigned W = $clog2(DIV)
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  output logic [W-1:0] o_cnt,
  output logic o_wrap
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } bgc_div_st_t;

  bgc_div_st_t st_r;
  bgc_div_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cnt = o_wrap ? '0 : st_r.cnt + 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_wrap = (st_r.cnt == W'(DIV - 1));
  assign o_cnt = st_r.cnt;

endmodule

// >>> bgc_top.sv
// Bridge gate control core: phase decode, enable, fault qualification, indicator pins.
//
// Functional notes
// - Each internal phase request is pin OR register bit, per side.
// - Lone high request sources the phase, lone low request sinks it.
// - Both requests zero or both one keep both gates low.
// - Disabled gate drive holds every gate output low.
// - Every phase decodes on its own, never touched by the others.
// - Indicator mode one gives a pulse train with a 100 ms period.
// - Pulse train is high 80 percent without fault, 20 percent with.
// - Indicator mode three outputs the system clock divided by 280000.
// - Serial output clock select drives the divided clock while deselected.
// - Drain fault qualifier is debounce at mode 0, blanking at 1; time programmable.
// - Overcurrent qualify mode one selects blanking instead of debounce.
// - Direct mode disables on low enable; watchdog mode on enable timeout.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module bgc_top #(
  parameter int unsigned CLK_DIV_RATIO = bgc_pkg::CLK_DIV_RATIO,
  parameter int unsigned FAULT_INDICATOR_PIN_PERIOD_CYC = bgc_pkg::FAULT_INDICATOR_PIN_PERIOD_CYC,
  parameter int unsigned EN_TIMEOUT_CYC = bgc_pkg::EN_TIMEOUT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_phase_a_high_pin,
  input wire logic i_phase_a_low_pin,
  input wire logic i_phase_b_high_pin,
  input wire logic i_phase_b_low_pin,
  input wire logic i_phase_c_high_pin,
  input wire logic i_phase_c_low_pin,
  input wire logic i_enable_pin,
  input wire logic i_drain_fault_raw,
  input wire logic i_overcurrent_raw,
  input wire logic i_serial_select_n,
  input wire logic i_serial_tx_bit,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic [2:0] o_upper_gate_out,
  output logic [2:0] o_lower_gate_out,
  output logic o_fault_indicator_pin,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe_n
);

  localparam int unsigned NS = 10;
  localparam int unsigned TW = $clog2(EN_TIMEOUT_CYC + 1);
  localparam int unsigned PW = $clog2(FAULT_INDICATOR_PIN_PERIOD_CYC);
  localparam int unsigned CW = $clog2(CLK_DIV_RATIO);
  localparam int unsigned HIGH_OK = FAULT_INDICATOR_PIN_PERIOD_CYC / 100 * bgc_pkg::DUTY_OK_PCT;
  localparam int unsigned HIGH_FLT = FAULT_INDICATOR_PIN_PERIOD_CYC / 100 * bgc_pkg::DUTY_FAULT_PCT;
  localparam int unsigned CLK_HALF = CLK_DIV_RATIO / 2;
  localparam logic [NS-1:0] SYNC_RST = 10'h200;

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic en_d;
    logic [TW-1:0] wd_cnt;
    logic wd_to;
    logic [2:0] ctrl_hi;
    logic [2:0] ctrl_lo;
    bgc_pkg::bgc_fault_indicator_pin_mode_t dmode;
    logic serial_out_clock_select;
    logic drain_fault_qualify_mode;
    logic overcurrent_qualify_mode;
    logic wdm;
    logic [5:0] qcode;
    logic [1:0] flt;
    logic [2:0] up;
    logic [2:0] dn;
    logic fault_indicator_pin;
    logic sdo;
    logic sdo_oe_n;
    logic [31:0] rdata;
  } bgc_top_st_t;

  bgc_top_st_t st_r;
  bgc_top_st_t st_nxt;

  logic [2:0] pin_hi;
  logic [2:0] pin_lo;
  logic [2:0] hi_req;
  logic [2:0] lo_req;
  logic [2:0] up_nxt;
  logic [2:0] dn_nxt;
  logic en_s;
  logic sel_n_s;
  logic drive_en;
  logic gate_on;
  logic any_fault;
  logic [5:0] qual_cyc;
  logic [PW-1:0] pcnt;
  logic [CW-1:0] ccnt;
  logic div_clk;

  bgc_qual_if vds_q ();
  bgc_qual_if oc_q ();

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised pins; only the second stage is read.
  assign pin_hi = {st_r.s2[4], st_r.s2[2], st_r.s2[0]};
  assign pin_lo = {st_r.s2[5], st_r.s2[3], st_r.s2[1]};
  assign en_s = st_r.s2[6];
  assign sel_n_s = st_r.s2[9];
  assign drive_en = st_r.wdm ? !st_r.wd_to : en_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Phase decode.
  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    assign hi_req[p] = pin_hi[p] | st_r.ctrl_hi[p];
    assign lo_req[p] = pin_lo[p] | st_r.ctrl_lo[p];
    assign up_nxt[p] = drive_en & hi_req[p] & !lo_req[p];
    assign dn_nxt[p] = drive_en & lo_req[p] & !hi_req[p];
  end

  assign gate_on = |({up_nxt, dn_nxt} & ~{st_r.up, st_r.dn});

  ////////////////////////////////////////////////////////////////////////////////
  // Fault qualifiers and counters.
  assign qual_cyc = (st_r.qcode < 6'(bgc_pkg::QUAL_MIN_CODE)) ?
                    6'(bgc_pkg::QUAL_MIN_CODE * bgc_pkg::QUAL_STEP_CYC) :
                    6'(st_r.qcode * bgc_pkg::QUAL_STEP_CYC);

  assign vds_q.raw = st_r.s2[7];
  assign vds_q.gate_on = gate_on;
  assign vds_q.blank_mode = st_r.drain_fault_qualify_mode;
  assign vds_q.qual_cyc = qual_cyc;
  assign oc_q.raw = st_r.s2[8];
  assign oc_q.gate_on = gate_on;
  assign oc_q.blank_mode = st_r.overcurrent_qualify_mode;
  assign oc_q.qual_cyc = qual_cyc;

  bgc_qualifier u_vds_qual (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .q(vds_q.qual)
  );

  bgc_qualifier u_oc_qual (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .q(oc_q.qual)
  );

  // Both counters are cleared by the device reset.
  bgc_divider #(.DIV(FAULT_INDICATOR_PIN_PERIOD_CYC), .W(PW)) u_pulse_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_cnt(pcnt),
    .o_wrap()
  );

  bgc_divider #(.DIV(CLK_DIV_RATIO), .W(CW)) u_clk_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_cnt(ccnt),
    .o_wrap()
  );

  assign div_clk = (ccnt < CW'(CLK_HALF));
  assign any_fault = (|st_r.flt) | vds_q.fault | oc_q.fault;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = {i_serial_select_n, i_overcurrent_raw, i_drain_fault_raw, i_enable_pin,
                 i_phase_c_low_pin, i_phase_c_high_pin, i_phase_b_low_pin,
                 i_phase_b_high_pin, i_phase_a_low_pin, i_phase_a_high_pin};
    st_nxt.s2 = st_r.s1;
    st_nxt.en_d = en_s;
    // A watchdog timeout is left again at the next enable edge.
    if (en_s != st_r.en_d)
    begin
      st_nxt.wd_cnt = '0;
      st_nxt.wd_to = 1'b0;
    end
    else if (st_r.wd_cnt < TW'(EN_TIMEOUT_CYC - 1))
    begin
      st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
    end
    else
    begin
      st_nxt.wd_to = 1'b1;
    end
    st_nxt.up = up_nxt;
    st_nxt.dn = dn_nxt;
    st_nxt.rdata = 32'h0;
    if (i_reg_wr && i_reg_addr == bgc_pkg::ADDR_CTRL)
    begin
      st_nxt.ctrl_hi = i_reg_wdata[bgc_pkg::CTRL_HI_LSB +: 3];
      st_nxt.ctrl_lo = i_reg_wdata[bgc_pkg::CTRL_LO_LSB +: 3];
    end
    if (i_reg_wr && i_reg_addr == bgc_pkg::ADDR_CFG)
    begin
      st_nxt.dmode = bgc_pkg::bgc_fault_indicator_pin_mode_t'(i_reg_wdata[bgc_pkg::CFG_DMODE_LSB +: 2]);
      st_nxt.serial_out_clock_select = i_reg_wdata[bgc_pkg::CFG_CKS_BIT];
      st_nxt.drain_fault_qualify_mode = i_reg_wdata[bgc_pkg::CFG_VDQ_BIT];
      st_nxt.overcurrent_qualify_mode = i_reg_wdata[bgc_pkg::CFG_OCQ_BIT];
      st_nxt.wdm = i_reg_wdata[bgc_pkg::CFG_WDM_BIT];
      st_nxt.qcode = i_reg_wdata[bgc_pkg::CFG_QUAL_LSB +: 6];
    end
    // A fault arriving with its clear stays set.
    if (i_reg_wr && i_reg_addr == bgc_pkg::ADDR_STAT)
    begin
      st_nxt.flt[0] = st_r.flt[0] & !i_reg_wdata[bgc_pkg::STAT_VDS_BIT];
      st_nxt.flt[1] = st_r.flt[1] & !i_reg_wdata[bgc_pkg::STAT_OC_BIT];
    end
    st_nxt.flt = st_nxt.flt | {oc_q.fault, vds_q.fault};
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        bgc_pkg::ADDR_CTRL:
        begin
          st_nxt.rdata[bgc_pkg::CTRL_HI_LSB +: 3] = st_r.ctrl_hi;
          st_nxt.rdata[bgc_pkg::CTRL_LO_LSB +: 3] = st_r.ctrl_lo;
        end
        bgc_pkg::ADDR_CFG:
        begin
          st_nxt.rdata[bgc_pkg::CFG_DMODE_LSB +: 2] = st_r.dmode;
          st_nxt.rdata[bgc_pkg::CFG_CKS_BIT] = st_r.serial_out_clock_select;
          st_nxt.rdata[bgc_pkg::CFG_VDQ_BIT] = st_r.drain_fault_qualify_mode;
          st_nxt.rdata[bgc_pkg::CFG_OCQ_BIT] = st_r.overcurrent_qualify_mode;
          st_nxt.rdata[bgc_pkg::CFG_WDM_BIT] = st_r.wdm;
          st_nxt.rdata[bgc_pkg::CFG_QUAL_LSB +: 6] = st_r.qcode;
        end
        bgc_pkg::ADDR_STAT:
        begin
          st_nxt.rdata[bgc_pkg::STAT_VDS_BIT] = st_r.flt[0];
          st_nxt.rdata[bgc_pkg::STAT_OC_BIT] = st_r.flt[1];
          st_nxt.rdata[bgc_pkg::STAT_EN_BIT] = drive_en;
          st_nxt.rdata[bgc_pkg::STAT_WDTO_BIT] = st_r.wd_to;
        end
        default:
        begin
          st_nxt.rdata = 32'h0;
        end
      endcase
    end
    case (st_r.dmode)
      bgc_pkg::FAULT_INDICATOR_PIN_LEVEL: st_nxt.fault_indicator_pin = !(|st_r.flt);
      bgc_pkg::FAULT_INDICATOR_PIN_PULSE: st_nxt.fault_indicator_pin = any_fault ? (pcnt < PW'(HIGH_FLT)) :
                                                     (pcnt < PW'(HIGH_OK));
      bgc_pkg::FAULT_INDICATOR_PIN_LIVE: st_nxt.fault_indicator_pin = !(vds_q.fault | oc_q.fault);
      bgc_pkg::FAULT_INDICATOR_PIN_CLOCK: st_nxt.fault_indicator_pin = div_clk;
      default: st_nxt.fault_indicator_pin = 1'b1;
    endcase
    if (!sel_n_s)
    begin
      st_nxt.sdo = i_serial_tx_bit;
      st_nxt.sdo_oe_n = 1'b0;
    end
    else if (st_r.serial_out_clock_select)
    begin
      st_nxt.sdo = div_clk;
      st_nxt.sdo_oe_n = 1'b0;
    end
    else
    begin
      st_nxt.sdo = 1'b0;
      st_nxt.sdo_oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
      st_r.s1 <= SYNC_RST;
      st_r.s2 <= SYNC_RST;
      st_r.dmode <= bgc_pkg::bgc_fault_indicator_pin_mode_t'(bgc_pkg::DMODE_RST);
      st_r.qcode <= bgc_pkg::QUAL_RST;
      st_r.ctrl_hi <= bgc_pkg::CTRL_RST;
      st_r.ctrl_lo <= bgc_pkg::CTRL_RST;
      st_r.fault_indicator_pin <= 1'b1;
      st_r.sdo_oe_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_upper_gate_out = st_r.up;
  assign o_lower_gate_out = st_r.dn;
  assign o_fault_indicator_pin = st_r.fault_indicator_pin;
  assign o_serial_data_out = st_r.sdo;
  assign o_serial_data_out_oe_n = st_r.sdo_oe_n;
  assign o_reg_rdata = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_pulse_ok_end;
    st_r.dmode == bgc_pkg::FAULT_INDICATOR_PIN_PULSE && !any_fault && pcnt == PW'(HIGH_OK);
  endsequence
  sequence s_pulse_flt_end;
    st_r.dmode == bgc_pkg::FAULT_INDICATOR_PIN_PULSE && any_fault && pcnt == PW'(HIGH_FLT);
  endsequence

  source_or_a: assert property (drive_en && hi_req[0] && !lo_req[0] |=> o_upper_gate_out[0] && !o_lower_gate_out[0]) else $error("phase A not sourcing");
  sink_drive_a: assert property (drive_en && lo_req[2] && !hi_req[2] |=> o_lower_gate_out[2] && !o_upper_gate_out[2]) else $error("phase C not sinking");
  both_off_a: assert property (hi_req[1] == lo_req[1] |=> !o_upper_gate_out[1] && !o_lower_gate_out[1]) else $error("phase B not off");
  disable_low_a: assert property (!drive_en |=> (o_upper_gate_out | o_lower_gate_out) == 3'h0) else $error("gates driven while disabled");
  phase_indep_a: assert property ($stable(hi_req[0]) && $stable(lo_req[0]) && $stable(drive_en) |=> $stable(o_upper_gate_out[0]) && $stable(o_lower_gate_out[0])) else $error("phase A moved by others");
  pulse_ok_a: assert property (s_pulse_ok_end |=> !o_fault_indicator_pin) else $error("pulse high past 80 percent");
  pulse_flt_a: assert property (s_pulse_flt_end |=> !o_fault_indicator_pin) else $error("pulse high past 20 percent");
  pulse_start_a: assert property (st_r.dmode == bgc_pkg::FAULT_INDICATOR_PIN_PULSE && pcnt == '0 |=> o_fault_indicator_pin) else $error("pulse period start low");
  fault_indicator_pin_clock_a: assert property (st_r.dmode == bgc_pkg::FAULT_INDICATOR_PIN_CLOCK && ccnt == CW'(CLK_HALF) |=> !o_fault_indicator_pin ##1 !o_fault_indicator_pin) else $error("divided clock wrong");
  sdo_clock_a: assert property (sel_n_s && st_r.serial_out_clock_select && ccnt == '0 |=> o_serial_data_out && !o_serial_data_out_oe_n) else $error("serial clock output wrong");
  vds_debounce_a: assert property (!st_r.drain_fault_qualify_mode && !vds_q.raw |=> !vds_q.fault) else $error("debounce passed low raw");
  vds_blank_a: assert property (st_r.drain_fault_qualify_mode && gate_on |=> !vds_q.fault) else $error("drain fault not blanked");
  oc_blank_a: assert property (st_r.overcurrent_qualify_mode && gate_on |=> !oc_q.fault) else $error("overcurrent not blanked");
  direct_en_a: assert property (!st_r.wdm && !en_s |=> (o_upper_gate_out | o_lower_gate_out) == 3'h0) else $error("enable low ignored");
  wd_timeout_a: assert property (st_r.wdm && st_r.wd_to |=> (o_upper_gate_out | o_lower_gate_out) == 3'h0) else $error("timeout ignored");
  sticky_set_a: assert property (vds_q.fault |=> st_r.flt[0]) else $error("fault flag lost");

endmodule

// >>> bgc_mcu_model.sv
// Microcontroller model driving the phase pins, the enable pin and the serial select.
`timescale 1ns/1ps
module bgc_mcu_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_use_pins,
  input wire logic [2:0] i_req_high,
  input wire logic [2:0] i_req_low,
  input wire logic i_enable,
  input wire logic i_select_n,
  output logic [2:0] o_high_pin,
  output logic [2:0] o_low_pin,
  output logic o_enable_pin,
  output logic o_select_n,
  output logic o_tx_bit
);
  // The tx bit flips every cycle, so a stale copy on the serial output never passes.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_high_pin <= 3'h0;
      o_low_pin <= 3'h0;
      o_enable_pin <= 1'b0;
      o_select_n <= 1'b1;
      o_tx_bit <= 1'b0;
    end
    else
    begin
      o_high_pin <= i_use_pins ? i_req_high : 3'h0;
      o_low_pin <= i_use_pins ? i_req_low : 3'h0;
      o_enable_pin <= i_enable;
      o_select_n <= i_select_n;
      o_tx_bit <= ~o_tx_bit;
    end
  end
endmodule

// >>> bridge_gate_control_logic_tb.sv
// Self-checking testbench for the bridge gate control core.
`timescale 1ns/1ps
module bridge_gate_control_logic_tb;
  localparam int LIMIT = 20000;
  logic i_clk_sys, i_rst_n, i_drain_fault_raw, i_overcurrent_raw, i_reg_wr, i_reg_rd;
  logic [7:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, v;
  logic [2:0] o_upper_gate_out, o_lower_gate_out, hp, lp, req_h, req_l;
  logic o_fault_indicator_pin, o_serial_data_out, o_serial_data_out_oe_n;
  logic en_pin, sel_n, tx, use_pins, en_cmd, sel_cmd;
  logic [5:0] r;
  int bad_count, num_checks, cyc, hi, tg, k, m, b;

  bgc_mcu_model i_mcu (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_use_pins(use_pins),
    .i_req_high(req_h), .i_req_low(req_l), .i_enable(en_cmd), .i_select_n(sel_cmd),
    .o_high_pin(hp), .o_low_pin(lp), .o_enable_pin(en_pin), .o_select_n(sel_n), .o_tx_bit(tx));

  bgc_top #(.CLK_DIV_RATIO(8), .FAULT_INDICATOR_PIN_PERIOD_CYC(200), .EN_TIMEOUT_CYC(50)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_phase_a_high_pin(hp[0]), .i_phase_a_low_pin(lp[0]),
    .i_phase_b_high_pin(hp[1]), .i_phase_b_low_pin(lp[1]),
    .i_phase_c_high_pin(hp[2]), .i_phase_c_low_pin(lp[2]),
    .i_enable_pin(en_pin), .i_drain_fault_raw(i_drain_fault_raw),
    .i_overcurrent_raw(i_overcurrent_raw), .i_serial_select_n(sel_n), .i_serial_tx_bit(tx),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_upper_gate_out(o_upper_gate_out),
    .o_lower_gate_out(o_lower_gate_out), .o_fault_indicator_pin(o_fault_indicator_pin),
    .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe_n(o_serial_data_out_oe_n));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      bad_count++;
      finish_test();
    end
  end

  task wt(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask

  task reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  task pulse(input int src, input int n);
    @(posedge i_clk_sys);
    if (src == 0) i_drain_fault_raw <= 1'b1;
    else i_overcurrent_raw <= 1'b1;
    wt(n);
    i_drain_fault_raw <= 1'b0;
    i_overcurrent_raw <= 1'b0;
    wt(4);
  endtask

  // Counts high samples and changes of the indicator or serial output over n cycles.
  task count_out(input int n, input logic ser, output int h, output int t);
    logic prev, cur;
    h = 0;
    t = 0;
    @(posedge i_clk_sys);
    #1 prev = ser ? o_serial_data_out : o_fault_indicator_pin;
    repeat (n)
    begin
      @(posedge i_clk_sys);
      #1 cur = ser ? o_serial_data_out : o_fault_indicator_pin;
      if (cur === 1'b1) h++;
      if (cur !== prev) t++;
      prev = cur;
    end
  endtask

  task fault_reg(input int src, input logic [31:0] cfg, input int n, input logic [1:0] exp);
    reg_wr(bgc_pkg::ADDR_STAT, 32'h3);
    reg_wr(bgc_pkg::ADDR_CFG, cfg);
    // Entering blank mode opens a window with the fault held off, so let it close first.
    wt(20);
    pulse(src, n);
    check(32'(o_fault_indicator_pin), 32'(exp == 2'h0));
    reg_rd(bgc_pkg::ADDR_STAT, v);
    check(v & 32'h3, 32'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_rst_n = 1'b0;
    i_drain_fault_raw = 1'b0;
    i_overcurrent_raw = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 32'h0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    use_pins = 1'b1;
    req_h = 3'h0;
    req_l = 3'h0;
    en_cmd = 1'b1;
    sel_cmd = 1'b1;
    wt(6);
    check({26'h0, o_lower_gate_out, o_upper_gate_out}, 32'h0);
    check(32'({o_fault_indicator_pin, o_serial_data_out_oe_n}), 32'h3);
    i_rst_n <= 1'b1;
    wt(2);
    reg_rd(bgc_pkg::ADDR_CTRL, v);
    check(v, 32'h0);
    reg_rd(bgc_pkg::ADDR_CFG, v);
    check(v & 32'h3f3f, 32'h1000);
    // Pins alone, register bits alone, then both mixed.
    for (m = 0; m < 3; m++)
      for (k = 0; k < 64; k++)
      begin
        r = (m == 0) ? 6'h0 : (m == 1) ? 6'(k) : 6'(k * 37 + 5);
        use_pins <= (m != 1);
        req_h <= 3'(k);
        req_l <= 3'(k >> 3);
        reg_wr(bgc_pkg::ADDR_CTRL, {25'h0, r[5:3], 1'b0, r[2:0]});
        wt(5);
        v[2:0] = ((m != 1) ? 3'(k) : 3'h0) | r[2:0];
        v[5:3] = ((m != 1) ? 3'(k >> 3) : 3'h0) | r[5:3];
        check({26'h0, o_lower_gate_out, o_upper_gate_out},
          {26'h0, v[5:3] & ~v[2:0], v[2:0] & ~v[5:3]});
      end
    reg_wr(bgc_pkg::ADDR_CTRL, 32'h0);
    use_pins <= 1'b1;
    req_h <= 3'h7;
    req_l <= 3'h0;
    en_cmd <= 1'b0;
    wt(6);
    check({26'h0, o_lower_gate_out, o_upper_gate_out}, 32'h0);
    en_cmd <= 1'b1;
    wt(6);
    check(32'(o_upper_gate_out), 32'h7);
    reg_wr(bgc_pkg::ADDR_CFG, 32'h1020);
    wt(60);
    check({26'h0, o_lower_gate_out, o_upper_gate_out}, 32'h0);
    reg_rd(bgc_pkg::ADDR_STAT, v);
    check(v & 32'h300, 32'h200);
    en_cmd <= 1'b0;
    wt(8);
    check(32'(o_upper_gate_out), 32'h7);
    en_cmd <= 1'b1;
    reg_wr(bgc_pkg::ADDR_CFG, 32'h1000);
    wt(30);
    // Debounce ignores a short burst; blanking outside a window passes it straight on.
    for (b = 0; b < 2; b++)
    begin
      fault_reg(b, 32'h1000, 10, 2'h0);
      fault_reg(b, 32'h1000 | (32'h8 << b), 10, 2'(1 << b));
    end
    fault_reg(0, 32'h0600, 10, 2'h1);
    fault_reg(0, 32'h0300, 4, 2'h0);
    reg_wr(bgc_pkg::ADDR_CFG, 32'h1002);
    @(posedge i_clk_sys);
    i_drain_fault_raw <= 1'b1;
    wt(25);
    check(32'(o_fault_indicator_pin), 32'h0);
    i_drain_fault_raw <= 1'b0;
    wt(5);
    check(32'(o_fault_indicator_pin), 32'h1);
    reg_wr(bgc_pkg::ADDR_CFG, 32'h1001);
    wt(3);
    count_out(200, 1'b0, hi, tg);
    check(32'(hi), 32'd40);
    reg_wr(bgc_pkg::ADDR_STAT, 32'h3);
    wt(3);
    count_out(200, 1'b0, hi, tg);
    check(32'(hi), 32'd160);
    check(32'(tg), 32'd2);
    reg_wr(bgc_pkg::ADDR_CFG, 32'h1003);
    wt(3);
    count_out(80, 1'b0, hi, tg);
    check({hi[15:0], tg[15:0]}, {16'd40, 16'd20});
    reg_wr(bgc_pkg::ADDR_CFG, 32'h1004);
    wt(3);
    count_out(80, 1'b1, hi, tg);
    check({hi[15:0], tg[15:0]}, {16'd40, 16'd20});
    check(32'(o_serial_data_out_oe_n), 32'h0);
    sel_cmd <= 1'b0;
    wt(5);
    repeat (4)
    begin
      @(posedge i_clk_sys);
      #1 check(32'({o_serial_data_out_oe_n, o_serial_data_out}), 32'({1'b0, ~tx}));
    end
    sel_cmd <= 1'b1;
    reg_wr(bgc_pkg::ADDR_CFG, 32'h1000);
    wt(5);
    check(32'(o_serial_data_out_oe_n), 32'h1);
    reg_rd(8'h0c, v);
    check(v, 32'h0);
    reg_rd(bgc_pkg::ADDR_CFG, v);
    check(v, 32'h1000);
    @(posedge i_clk_sys);
    #1 check(o_reg_rdata, 32'h0);
    finish_test();
  end
endmodule
